// >>> include/rscl_consts.svh
`ifndef RSCL_CONSTS_SVH
`define RSCL_CONSTS_SVH

`define RSCL_CLK_PERIOD_NS 100
`define RSCL_ADDR_W        5
`define RSCL_ADDR_PULL_UP  5'h01
`define RSCL_ADDR_RST      5'h01
`define RSCL_MODE_RST      1'h0
`define RSCL_AN_RST        1'h1
`define RSCL_RST_MIN_NS    1000
`define RSCL_RST_MIN_CYC   ((`RSCL_RST_MIN_NS + `RSCL_CLK_PERIOD_NS - 1) / `RSCL_CLK_PERIOD_NS)
`define RSCL_SETTLE_NS     1000
`define RSCL_SETTLE_CYC    ((`RSCL_SETTLE_NS + `RSCL_CLK_PERIOD_NS - 1) / `RSCL_CLK_PERIOD_NS)
`define RSCL_REF_LOSS_NS   2000
`define RSCL_REF_LOSS_CYC  (`RSCL_REF_LOSS_NS / `RSCL_CLK_PERIOD_NS)
`define RSCL_BLINK_NS      50000000
`define RSCL_BLINK_CYC     (`RSCL_BLINK_NS / `RSCL_CLK_PERIOD_NS)
`define RSCL_REF_MII_MHZ   25
`define RSCL_REF_RMII_MHZ  50

`endif

// >>> include/rscl_pkg.sv
package rscl_pkg;
  typedef enum logic [1:0] {
    RSCL_ST_HOLD   = 2'b00,
    RSCL_ST_SAMPLE = 2'b01,
    RSCL_ST_SETTLE = 2'b10,
    RSCL_ST_RUN    = 2'b11
  } rscl_state_t;

  typedef enum logic {
    RSCL_LED_STEADY = 1'b0,
    RSCL_LED_BLINK  = 1'b1
  } rscl_led_mode_t;

  typedef enum logic {
    RSCL_MAC_MII  = 1'b0,
    RSCL_MAC_RMII = 1'b1
  } rscl_mac_mode_t;

  typedef struct packed {
    logic [4:0]     addr;
    rscl_mac_mode_t mac_mode;
    logic           an;
  } rscl_strap_t;
endpackage

// >>> include/rscl_if.sv
`timescale 1ns/1ps
interface rscl_if;
  import rscl_pkg::*;
  logic           sample;
  rscl_strap_t    strap_pins;
  rscl_strap_t    strap_q;
  logic           run;
  rscl_led_mode_t led_mode;
  logic           link_good;
  logic           activity;
  logic           led_on;

  modport top_mp   (output sample, strap_pins, run, led_mode, link_good, activity,
                    input strap_q, led_on);
  modport strap_mp (input sample, strap_pins, output strap_q);
  modport led_mp   (input run, led_mode, link_good, activity, output led_on);
endinterface

// >>> verilog/rscl_strap.sv
`timescale 1ns/1ps
`include "rscl_consts.svh"
module rscl_strap (
  input  wire logic core_clk,   // system clock
  input  wire logic rst_n,      // async reset, active low
  input  wire logic clk_en,     // freezes state while low
  rscl_if.strap_mp  sif         // sample strobe and strap levels
);
  import rscl_pkg::*;

  rscl_strap_t strap_r;
  rscl_strap_t strap_nxt;

  always_comb begin
    strap_nxt = strap_r;
    if (sif.sample) begin
      strap_nxt = sif.strap_pins;
    end
  end

  // reset values equal the pull defaults, so an unstrapped board reads the same
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_r.addr     <= `RSCL_ADDR_RST;
      strap_r.mac_mode <= rscl_mac_mode_t'(`RSCL_MODE_RST);
      strap_r.an       <= `RSCL_AN_RST;
    end else if (clk_en) begin
      strap_r <= strap_nxt;
    end
  end

  assign sif.strap_q = strap_r;
endmodule

// >>> verilog/rscl_led.sv
`timescale 1ns/1ps
module rscl_led #(
  parameter int BLINK_CYCLES = 500000
) (
  input  wire logic core_clk,   // system clock
  input  wire logic rst_n,      // async reset, active low
  input  wire logic clk_en,     // freezes state while low
  rscl_if.led_mp    lif         // mode, link, activity in; led level out
);
  import rscl_pkg::*;

  localparam int CW = $clog2(BLINK_CYCLES + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          off_phase_r;
  logic          off_phase_nxt;
  logic          busy_r;
  logic          busy_nxt;
  logic          led_r;
  logic          led_nxt;

  // one blink is a full off then on phase, so short bursts stay visible
  always_comb begin
    cnt_nxt       = cnt_r;
    off_phase_nxt = off_phase_r;
    busy_nxt      = busy_r;
    led_nxt       = 1'b0;
    if (busy_r) begin
      if (cnt_r == CW'(BLINK_CYCLES - 1)) begin
        cnt_nxt       = '0;
        off_phase_nxt = ~off_phase_r;
        if (!off_phase_r && !lif.activity) begin
          busy_nxt = 1'b0;
        end
      end else begin
        cnt_nxt = cnt_r + CW'(1);
      end
    end else if (lif.activity && lif.led_mode == RSCL_LED_BLINK) begin
      busy_nxt      = 1'b1;
      off_phase_nxt = 1'b1;
      cnt_nxt       = '0;
    end
    if (lif.run && lif.link_good) begin
      case (lif.led_mode)
        RSCL_LED_STEADY: led_nxt = 1'b1;
        RSCL_LED_BLINK:  led_nxt = ~(busy_nxt && off_phase_nxt);
        default:           led_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r       <= '0;
      off_phase_r <= 1'b0;
      busy_r      <= 1'b0;
      led_r       <= 1'b0;
    end else if (clk_en) begin
      cnt_r       <= cnt_nxt;
      off_phase_r <= off_phase_nxt;
      busy_r      <= busy_nxt;
      led_r       <= led_nxt;
    end
  end

  assign lif.led_on = led_r;
endmodule

// >>> verilog/rscl_top.sv
`timescale 1ns/1ps
`include "rscl_consts.svh"
module rscl_top #(
  parameter int BLINK_CYCLES = `RSCL_BLINK_CYC,
  parameter int SETTLE_CYC   = `RSCL_SETTLE_CYC,
  parameter int REF_LOSS_CYC = `RSCL_REF_LOSS_CYC
) (
  input  wire logic                   core_clk,               // system clock, 10 MHz
  input  wire logic                   rst_n,                  // async reset, active low
  input  wire logic                   clk_en,                 // freezes all state while low
  input  wire logic                   ref_clk_in,             // reference clock pin level
  output logic                        crystal_drive_out,      // inverted reference, crystal drive
  output logic                        sys_clk_out,            // registered reference clock copy out
  input  wire logic [4:0]             station_addr_strap_in,  // address strap pin levels
  output logic [4:0]                  station_addr_strap_out, // functional drive: rxd3..0, col
  output logic [4:0]                  station_addr_strap_oe_n,// low while driving
  output logic [4:0]                  station_addr_pull_up,   // 1 pull-up, 0 pull-down
  input  wire logic                   mode_strap_in,          // mac mode strap pin level
  output logic                        mode_strap_out,         // functional drive: rx_dv
  output logic                        mode_strap_oe_n,        // low while driving
  input  wire logic                   link_indicator_in,      // led pin level, sampled at reset
  output logic                        link_indicator_out,     // led drive, 1 = on
  output logic                        link_indicator_oe_n,    // low while driving
  input  wire logic                   col_fn,                 // collision from data path
  input  wire logic [3:0]             rxd_fn,                 // receive data from data path
  input  wire logic                   rx_dv_fn,               // receive valid from data path
  input  wire rscl_pkg::rscl_led_mode_t led_mode_sel,         // led mode select
  input  wire logic                   link_good,              // link status
  input  wire logic                   tx_active,              // transmitter busy
  input  wire logic                   rx_active,              // receiver busy
  input  wire logic                   addr_wr_en,             // address write strobe
  input  wire logic [4:0]             addr_wr_data,           // address write value
  output logic [4:0]                  port_control_addr,      // current station address
  output logic [4:0]                  strap_addr,             // address as strapped
  output rscl_pkg::rscl_mac_mode_t    mac_mode,               // strapped mac interface mode
  output logic [5:0]                  ref_clk_mhz,            // expected reference rate
  output logic                        an_strap,               // advertise strap level
  output logic                        isolate,                // mac data interface isolated
  output logic                        ref_clk_ok,             // reference clock toggling
  output logic                        ready                   // reset process finished
);
  import rscl_pkg::*;

  localparam int SCW = $clog2(SETTLE_CYC + 1);
  localparam int RCW = $clog2(REF_LOSS_CYC + 1);

  localparam logic [4:0] PULL_DIR = `RSCL_ADDR_PULL_UP;

  // strap-capable pins stay released until the sample state is over
  function automatic logic drive_phase(input rscl_state_t st);
    drive_phase = (st == RSCL_ST_SETTLE || st == RSCL_ST_RUN);
  endfunction

  // a pin driven only once strapping is over and the interface is not isolated
  function automatic logic mac_oe_n(input rscl_state_t st, input logic iso);
    mac_oe_n = !(drive_phase(st) && !iso);
  endfunction

  rscl_if sig ();

  rscl_strap u_strap (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .sif      (sig.strap_mp)
  );

  rscl_led #(
    .BLINK_CYCLES (BLINK_CYCLES)
  ) u_led (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .lif      (sig.led_mp)
  );

  // ---------------- reset process sequencer
  rscl_state_t    state_r;
  rscl_state_t    state_nxt;
  logic [SCW-1:0] settle_r;
  logic [SCW-1:0] settle_nxt;

  always_comb begin
    state_nxt  = state_r;
    settle_nxt = settle_r;
    case (state_r)
      RSCL_ST_HOLD: begin
        state_nxt = RSCL_ST_SAMPLE;
      end
      RSCL_ST_SAMPLE: begin
        state_nxt  = RSCL_ST_SETTLE;
        settle_nxt = '0;
      end
      RSCL_ST_SETTLE: begin
        if (settle_r == SCW'(SETTLE_CYC - 1)) begin
          state_nxt = RSCL_ST_RUN;
        end else begin
          settle_nxt = settle_r + SCW'(1);
        end
      end
      RSCL_ST_RUN: begin
        state_nxt = RSCL_ST_RUN;
      end
      default: begin
        state_nxt = RSCL_ST_HOLD;
      end
    endcase
  end

  // any low level on rst_n restarts the whole sequence and reloads straps
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= RSCL_ST_HOLD;
      settle_r <= '0;
    end else if (clk_en) begin
      state_r  <= state_nxt;
      settle_r <= settle_nxt;
    end
  end

  // strap levels go to the capture register in the sample state only
  assign sig.sample              = (state_r == RSCL_ST_SAMPLE);
  assign sig.strap_pins.addr     = station_addr_strap_in;
  assign sig.strap_pins.mac_mode = rscl_mac_mode_t'(mode_strap_in);
  assign sig.strap_pins.an       = link_indicator_in;

  // ---------------- station address and isolate
  logic [4:0] addr_r;
  logic [4:0] addr_nxt;
  logic       iso_r;
  logic       iso_nxt;

  always_comb begin
    addr_nxt = addr_r;
    iso_nxt  = iso_r;
    if (state_r == RSCL_ST_SETTLE && settle_r == '0) begin
      addr_nxt = sig.strap_q.addr;
      iso_nxt  = (sig.strap_q.addr == 5'h00);
    end else if (addr_wr_en && state_r == RSCL_ST_RUN) begin
      // software address writes never touch isolate
      addr_nxt = addr_wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= `RSCL_ADDR_RST;
      iso_r  <= 1'b0;
    end else if (clk_en) begin
      addr_r <= addr_nxt;
      iso_r  <= iso_nxt;
    end
  end

  // ---------------- reference clock forwarding and watch
  logic           ref_q_r;
  logic           ref_q_nxt;
  logic           xtal_r;
  logic           xtal_nxt;
  logic           ref_prev_r;
  logic           ref_prev_nxt;
  logic [RCW-1:0] idle_r;
  logic [RCW-1:0] idle_nxt;
  logic           ref_ok_r;
  logic           ref_ok_nxt;

  // output follows the reference whichever mode; rate comes from the oscillator
  always_comb begin
    ref_q_nxt    = ref_clk_in;
    xtal_nxt     = ~ref_clk_in;
    ref_prev_nxt = ref_q_r;
    idle_nxt     = idle_r;
    ref_ok_nxt   = ref_ok_r;
    if (ref_q_r != ref_prev_r) begin
      idle_nxt   = '0;
      ref_ok_nxt = 1'b1;
    end else if (idle_r == RCW'(REF_LOSS_CYC - 1)) begin
      ref_ok_nxt = 1'b0;
    end else begin
      idle_nxt = idle_r + RCW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q_r    <= 1'b0;
      xtal_r     <= 1'b1;
      ref_prev_r <= 1'b0;
      idle_r     <= '0;
      ref_ok_r   <= 1'b0;
    end else if (clk_en) begin
      ref_q_r    <= ref_q_nxt;
      xtal_r     <= xtal_nxt;
      ref_prev_r <= ref_prev_nxt;
      idle_r     <= idle_nxt;
      ref_ok_r   <= ref_ok_nxt;
    end
  end

  assign sys_clk_out       = ref_q_r;
  assign crystal_drive_out = xtal_r;
  assign ref_clk_ok        = ref_ok_r;

  // MAC reference use of sys_clk_out in RMII is left to the board timing check
  always_comb begin
    case (sig.strap_q.mac_mode)
      RSCL_MAC_MII:  ref_clk_mhz = 6'(`RSCL_REF_MII_MHZ);
      RSCL_MAC_RMII: ref_clk_mhz = 6'(`RSCL_REF_RMII_MHZ);
      default:       ref_clk_mhz = 6'(`RSCL_REF_MII_MHZ);
    endcase
  end

  // ---------------- functional pin drive after strapping
  logic [4:0] mac_fn;
  assign mac_fn = {rxd_fn, col_fn};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_addr_pin
      assign station_addr_strap_out[gi]  = mac_fn[gi];
      assign station_addr_strap_oe_n[gi] = mac_oe_n(state_r, iso_r);
      assign station_addr_pull_up[gi]    = PULL_DIR[gi];
    end
  endgenerate

  assign mode_strap_out  = rx_dv_fn;
  assign mode_strap_oe_n = mac_oe_n(state_r, iso_r);

  // led pin is a strap too, so it stays released until sampling is done
  assign sig.run       = (state_r == RSCL_ST_RUN);
  assign sig.led_mode  = led_mode_sel;
  assign sig.link_good = link_good;
  assign sig.activity  = tx_active | rx_active;

  assign link_indicator_out  = sig.led_on;
  assign link_indicator_oe_n = !drive_phase(state_r);

  // ---------------- status
  assign port_control_addr = addr_r;
  assign strap_addr        = sig.strap_q.addr;
  assign mac_mode          = sig.strap_q.mac_mode;
  assign an_strap          = sig.strap_q.an;
  assign isolate           = iso_r;
  assign ready             = (state_r == RSCL_ST_RUN);
endmodule

// >>> verification/rscl_top_props.sv
`timescale 1ns/1ps
module rscl_top_props
  import rscl_pkg::*;
#(
  parameter int SETTLE_CYC = 10
) (
  input wire logic                    core_clk,                // clock
  input wire logic                    rst_n,                   // reset, active low
  input wire logic                    clk_en,                  // clock enable
  input wire logic                    ref_clk_in,              // reference level
  input wire logic                    sys_clk_out,             // clock copy
  input wire logic [4:0]              station_addr_strap_oe_n, // strap pin enables
  input wire rscl_pkg::rscl_led_mode_t led_mode_sel,           // led mode
  input wire logic                    link_good,               // link status
  input wire logic                    tx_active,               // tx busy
  input wire logic                    rx_active,               // rx busy
  input wire logic                    link_indicator_out,      // led drive
  input wire logic [4:0]              strap_addr,              // strapped address
  input wire rscl_pkg::rscl_mac_mode_t mac_mode,               // mac mode
  input wire logic [5:0]              ref_clk_mhz,             // reference rate
  input wire logic                    isolate,                 // isolate flag
  input wire logic                    ready                    // reset done
);
  localparam int RDY_MAX = SETTLE_CYC + 4;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_rate;
    ref_clk_mhz == (mac_mode == RSCL_MAC_RMII ? 6'h32 : 6'h19);
  endproperty
  a_rate: assert property (p_rate) else $error("reference rate wrong");
  property p_sys_copy;
    ready && $past(clk_en) |-> sys_clk_out == $past(ref_clk_in);
  endproperty
  a_sys_copy: assert property (p_sys_copy) else $error("clock copy wrong");
  property p_led_m1;
    $past(ready) && $past(led_mode_sel) == RSCL_LED_STEADY |-> link_indicator_out == $past(link_good);
  endproperty
  a_led_m1: assert property (p_led_m1) else $error("link led wrong");
  property p_led_off;
    $past(ready) && !$past(link_good) |-> !link_indicator_out;
  endproperty
  a_led_off: assert property (p_led_off) else $error("led on without link");
  // with short blink count the led cannot stay lit eight cycles while busy
  property p_blink;
    not ((ready && led_mode_sel == RSCL_LED_BLINK && link_good && (tx_active || rx_active)
          && link_indicator_out)[*8]);
  endproperty
  a_blink: assert property (p_blink) else $error("led not blinking");
  property p_steady;
    (ready && led_mode_sel == RSCL_LED_BLINK && link_good && !tx_active && !rx_active)[*6]
      |-> link_indicator_out;
  endproperty
  a_steady: assert property (p_steady) else $error("idle led not steady");
  property p_rdy_time;
    $rose(rst_n) |-> ##[3:RDY_MAX] ready;
  endproperty
  a_rdy_time: assert property (p_rdy_time) else $error("reset process too long");
  property p_strap_hold;
    ready && $past(ready) |-> $stable(strap_addr) && $stable(mac_mode);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
  property p_iso;
    $rose(ready) |-> isolate == (strap_addr == 5'h00);
  endproperty
  a_iso: assert property (p_iso) else $error("isolate wrong");
  property p_iso_stable;
    ready && $past(ready) |-> $stable(isolate);
  endproperty
  a_iso_stable: assert property (p_iso_stable) else $error("isolate moved");
  property p_oe_rst;
    disable iff (1'b0) !rst_n |-> &station_addr_strap_oe_n;
  endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("strap pin driven in reset");
  property p_drive;
    ready |-> station_addr_strap_oe_n == (isolate ? 5'h1f : 5'h00);
  endproperty
  a_drive: assert property (p_drive) else $error("pin role wrong");

  c_blink: cover property (ready && led_mode_sel == RSCL_LED_BLINK && link_good
                           && tx_active && !link_indicator_out);
  c_iso: cover property (ready && isolate);
  c_rmii: cover property (ready && mac_mode == RSCL_MAC_RMII);
endmodule

bind rscl_top rscl_top_props #(.SETTLE_CYC(SETTLE_CYC)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .ref_clk_in(ref_clk_in),
  .sys_clk_out(sys_clk_out),
  .station_addr_strap_oe_n(station_addr_strap_oe_n), .led_mode_sel(led_mode_sel),
  .link_good(link_good), .tx_active(tx_active), .rx_active(rx_active),
  .link_indicator_out(link_indicator_out), .strap_addr(strap_addr), .mac_mode(mac_mode),
  .ref_clk_mhz(ref_clk_mhz), .isolate(isolate), .ready(ready));

// >>> verification/rscl_board.sv
`timescale 1ns/1ps
module rscl_board (
  input  wire logic [4:0] addr_res_en,  // external strap fitted
  input  wire logic [4:0] addr_res_val, // level of that strap
  input  wire logic       mode_res_hi,  // rmii pull-up fitted
  input  wire logic [4:0] addr_drv,     // device drive
  input  wire logic [4:0] addr_oe_n,    // low while device drives
  input  wire logic [4:0] addr_pull_up, // internal pull direction
  input  wire logic       mode_drv,     // device drive
  input  wire logic       mode_oe_n,    // low while device drives
  input  wire logic       led_drv,      // device drive
  input  wire logic       led_oe_n,     // low while device drives
  output logic [4:0]      addr_pin,     // resolved level
  output logic            mode_pin,     // resolved level
  output logic            led_pin       // resolved level
);
  // device drive beats the external strap, which beats the weak internal pull
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      addr_pin[i] = !addr_oe_n[i] ? addr_drv[i] :
                    addr_res_en[i] ? addr_res_val[i] : addr_pull_up[i];
    end
    mode_pin = !mode_oe_n ? mode_drv : mode_res_hi;
    led_pin = !led_oe_n ? led_drv : 1'b1;
  end
endmodule

// >>> verification/reset_strap_clock_led_bench.sv
`timescale 1ns/1ps
module reset_strap_clock_led_bench;
  import rscl_pkg::*;
  logic           core_clk, rst_n, clk_en, ref_clk_in, xtal, sys_clk, mode_out, mode_oe_n;
  logic           mode_pin, led_out, led_oe_n, led_pin, col_fn, rx_dv_fn, link_good, mode_hi;
  logic           tx_active, rx_active, addr_wr_en, an_strap, isolate, ref_ok, ready;
  logic [3:0]     rxd_fn;
  logic [4:0]     a_out, a_oe_n, a_pu, a_pin, res_en, res_val, wr_data, pc_addr, s_addr;
  logic [5:0]     mhz;
  logic           ref_run;
  rscl_led_mode_t led_mode;
  rscl_mac_mode_t mac_mode;
  int             mismatches, num_checks, seed, k;

  rscl_top #(.BLINK_CYCLES(4), .SETTLE_CYC(10), .REF_LOSS_CYC(20)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .ref_clk_in(ref_clk_in),
    .crystal_drive_out(xtal), .sys_clk_out(sys_clk), .station_addr_strap_in(a_pin),
    .station_addr_strap_out(a_out), .station_addr_strap_oe_n(a_oe_n),
    .station_addr_pull_up(a_pu), .mode_strap_in(mode_pin), .mode_strap_out(mode_out),
    .mode_strap_oe_n(mode_oe_n), .link_indicator_in(led_pin), .link_indicator_out(led_out),
    .link_indicator_oe_n(led_oe_n), .col_fn(col_fn), .rxd_fn(rxd_fn), .rx_dv_fn(rx_dv_fn),
    .led_mode_sel(led_mode), .link_good(link_good), .tx_active(tx_active),
    .rx_active(rx_active), .addr_wr_en(addr_wr_en), .addr_wr_data(wr_data),
    .port_control_addr(pc_addr), .strap_addr(s_addr), .mac_mode(mac_mode),
    .ref_clk_mhz(mhz), .an_strap(an_strap), .isolate(isolate), .ref_clk_ok(ref_ok),
    .ready(ready));

  rscl_board board (
    .addr_res_en(res_en), .addr_res_val(res_val), .mode_res_hi(mode_hi), .addr_drv(a_out),
    .addr_oe_n(a_oe_n), .addr_pull_up(a_pu), .mode_drv(mode_out), .mode_oe_n(mode_oe_n),
    .led_drv(led_out), .led_oe_n(led_oe_n), .addr_pin(a_pin), .mode_pin(mode_pin),
    .led_pin(led_pin));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // reference can be stopped to see the loss detector fall
  always @(negedge core_clk)
    if (ref_run) ref_clk_in <= ~ref_clk_in;

  function automatic logic [4:0] exp_addr(logic [4:0] en, logic [4:0] val);
    return (en & val) | (~en & 5'h01);
  endfunction

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h got %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_reset(logic [4:0] en, logic [4:0] val, logic hi);
    @(negedge core_clk);
    rst_n = 1'b0;
    res_en = en;
    res_val = val;
    mode_hi = hi;
    // 12 cycles of 100 ns keeps the low pulse above the minimum
    repeat (12) @(negedge core_clk);
    check("oe_rst", 8'h7f, {1'b0, a_oe_n, mode_oe_n, led_oe_n});
    check("rst_a", 8'h08, {s_addr, ready, isolate, sys_clk});
    check("rst_b", 8'ha1, {xtal, led_out, an_strap, 1'(mac_mode), pc_addr[3:0]});
    rst_n = 1'b1;
    for (k = 0; k < 40 && ready !== 1'b1; k++) @(negedge core_clk);
    if (ready !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
  endtask

  initial begin
    logic [4:0] e;
    logic       hm;
    int         lows;
    {ref_clk_in, col_fn, rx_dv_fn, link_good, tx_active, rx_active, addr_wr_en} = '0;
    {rxd_fn, wr_data, res_en, res_val, mode_hi} = '0;
    rst_n = 1'b1;
    ref_run = 1'b1;
    clk_en = 1'b1;
    led_mode = RSCL_LED_STEADY;
    mismatches = 0;
    num_checks = 0;
    seed = 80;
    // a true falling edge, so the asynchronous reset acts before the first clock
    #1 rst_n = 1'b0;
    for (int r = 0; r < 6; r++) begin
      case (r)
        0: do_reset(5'h00, 5'h00, 1'b0);
        1: do_reset(5'h1f, 5'h00, 1'b0);
        2: do_reset(5'h1f, 5'h1f, 1'b1);
        default: do_reset(5'($random(seed)), 5'($random(seed)), 1'($random(seed)));
      endcase
      e = exp_addr(res_en, res_val);
      hm = mode_hi;
      check("strap_addr", 8'(e), 8'(s_addr));
      check("port_addr", 8'(e), 8'(pc_addr));
      check("mac_mode", 8'(hm), 8'(mac_mode));
      check("ref_mhz", hm ? 8'h32 : 8'h19, 8'(mhz));
      check("isolate", 8'(e == 5'h00), 8'(isolate));
      check("an_strap", 8'h01, 8'(an_strap));
      check("clk_ok", 8'h01, 8'(ref_ok));
      {rxd_fn, col_fn, rx_dv_fn} = 6'($random(seed));
      #1;
      check("sys_clk", {6'h0, sys_clk, xtal}, {6'h0, ~ref_clk_in, ref_clk_in});
      check("addr_pins", 8'(isolate ? e : {rxd_fn, col_fn}), 8'(a_pin));
      check("mode_pin", 8'(isolate ? hm : rx_dv_fn), 8'(mode_pin));
      res_val = ~res_val;
      mode_hi = ~mode_hi;
      addr_wr_en = 1'b1;
      wr_data = 5'($random(seed));
      @(negedge core_clk);
      check("port_wr", 8'(wr_data), 8'(pc_addr));
      wr_data = 5'h00;
      @(negedge core_clk);
      addr_wr_en = 1'b0;
      check("held", {2'b0, e, hm}, {2'b0, s_addr, 1'(mac_mode)});
      check("wr_zero", 8'h00, {3'b0, pc_addr});
      check("iso_kept", 8'(e == 5'h00), 8'(isolate));
    end
    // frozen core: the clock copy must not follow the reference
    clk_en = 1'b0;
    hm = sys_clk;
    repeat (4) @(negedge core_clk);
    check("frozen", 8'(hm), 8'(sys_clk));
    clk_en = 1'b1;
    ref_run = 1'b0;
    repeat (25) @(negedge core_clk);
    check("clk_lost", 8'h00, 8'(ref_ok));
    ref_run = 1'b1;
    repeat (3) @(negedge core_clk);
    check("clk_back", 8'h01, 8'(ref_ok));
    link_good = 1'b1;
    for (int m = 0; m < 3; m++) begin
      led_mode = rscl_led_mode_t'(m != 0);
      tx_active = (m < 2);
      rx_active = (m == 2);
      lows = 0;
      repeat (12) begin
        @(negedge core_clk);
        lows += int'(!led_out);
      end
      check("led_lows", 8'(m == 0 ? 0 : 1), 8'(m == 0 ? lows : (lows >= 2)));
    end
    {tx_active, rx_active} = 2'b00;
    repeat (8) @(negedge core_clk);
    check("led_steady", 8'h01, 8'(led_out));
    link_good = 1'b0;
    repeat (2) @(negedge core_clk);
    check("led_down", 8'h00, 8'(led_out));
    wrap_up();
  end
endmodule
